// ---- verilog/tco_regs.svh ----
// Purpose: register offsets, field positions and reset values of the torque cut-off block
// Assumes: APB, 32-bit data, word-aligned registers
// Notes:   definitions only
`ifndef TCO_REGS_SVH
`define TCO_REGS_SVH

`define TCO_OFF_CTRL       12'h000
`define TCO_OFF_SAFETY     12'h004
`define TCO_OFF_SOURCE     12'h008
`define TCO_OFF_ENABLES    12'h00C
`define TCO_OFF_STAGE      12'h010
`define TCO_OFF_FAULTS     12'h014
`define TCO_OFF_ALARMS     12'h018

`define TCO_CTRL_ON        0
`define TCO_CTRL_RAMPSTOP  1
`define TCO_CTRL_BUSREQ    2
`define TCO_CTRL_BRAKE     3

`define TCO_SAF_SELECTED   0
`define TCO_SAF_ACTIVE     1
`define TCO_SRC_BUS        20
`define TCO_SRC_TERM       17
`define TCO_ENA_INHIBIT    0

`define TCO_STAGE_READY    8'h00
`define TCO_CTRL_RESET     4'h0
`define TCO_ADDR_W         12

`endif

// ---- verilog/tco_pkg.sv ----
// Purpose: types of the torque cut-off block
// Assumes: included register header for widths
// Notes:   no constants beyond types
`include "tco_regs.svh"
`default_nettype none
package tco_pkg;
  typedef enum logic [1:0] {
    TCO_IDLE,
    TCO_RUN,
    TCO_CUTOFF,
    TCO_INHIBIT
  } tco_mode_t;

  typedef struct packed {
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [`TCO_ADDR_W-1:0]   paddr;
    logic [31:0]              pwdata;
  } tco_apb_req_t;

  typedef struct packed {
    tco_mode_t   mode;
    logic [3:0]  ctrl;
    logic        on_prev;
    logic        rampstop_seen;
    logic [2:0]  term_sync;
    logic        term_req;
    logic        selected;
    logic        active;
    logic        bus_src;
    logic        term_src;
    logic        gate_en;
    logic        brake_hold;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tco_state_t;
endpackage
`default_nettype wire

// ---- verilog/tco_torque_cutoff.sv ----
// Purpose: torque cut-off control and status logic with APB register access
// Assumes: pclk 20 MHz, presetn async active low, terminal request is asynchronous
// Notes:   one-cycle APB answer; fault and alarm buffers carry no safety entries
//
// Chosen here: the APB interface to the registers and the register addresses.
`include "tco_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tco_torque_cutoff (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`TCO_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  input  wire logic                   term_cutoff_req,
  output var  logic                   gate_enable,
  output var  logic                   brake_apply,
  output var  logic                   cutoff_active
);

  tco_pkg::tco_state_t   st;
  tco_pkg::tco_state_t   next_st;
  tco_pkg::tco_apb_req_t req;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  ////////////////////////////////////////////////////////////////////////////
  logic        bus_req;
  logic        any_req;
  logic        access;
  logic        wr_ctrl;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [3:0]  ctrl_new;

  always_comb begin
    access  = req.psel && req.penable && !st.pready;
    wr_ctrl = access && req.pwrite && (req.paddr == `TCO_OFF_CTRL);
    ctrl_new = wr_ctrl ? req.pwdata[3:0] : st.ctrl;
    bus_req = st.ctrl[`TCO_CTRL_BUSREQ];
    any_req = bus_req || st.term_req;
    rd_ok   = 1'b1;
    rd_val  = 32'h0000_0000;
    unique case (req.paddr)
      `TCO_OFF_CTRL: begin
        rd_val[3:0] = st.ctrl;
      end
      `TCO_OFF_SAFETY: begin
        rd_val[`TCO_SAF_SELECTED] = st.selected;
        rd_val[`TCO_SAF_ACTIVE]   = st.active;
      end
      `TCO_OFF_SOURCE: begin
        rd_val[`TCO_SRC_BUS]  = st.bus_src;
        rd_val[`TCO_SRC_TERM] = st.term_src;
      end
      `TCO_OFF_ENABLES: begin
        rd_val[`TCO_ENA_INHIBIT] = (st.mode == tco_pkg::TCO_INHIBIT);
      end
      `TCO_OFF_STAGE: begin
        rd_val[7:0] = `TCO_STAGE_READY;
      end
      `TCO_OFF_FAULTS, `TCO_OFF_ALARMS: begin
        rd_val = 32'h0000_0000;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st           = st;
    next_st.pready    = access;
    next_st.pslverr   = access && !rd_ok;
    next_st.prdata    = (access && !req.pwrite && rd_ok) ? rd_val : 32'h0000_0000;
    next_st.ctrl      = ctrl_new;
    next_st.on_prev   = st.ctrl[`TCO_CTRL_ON];
    next_st.term_sync = {st.term_sync[1:0], term_cutoff_req};
    if (st.term_sync[2] == st.term_sync[1]) begin
      next_st.term_req = st.term_sync[2];
    end
    next_st.selected = any_req;
    next_st.bus_src  = bus_req;
    next_st.term_src = st.term_req;
    unique case (st.mode)
      tco_pkg::TCO_IDLE: begin
        if (any_req) begin
          next_st.mode = tco_pkg::TCO_CUTOFF;
        end else if (st.ctrl[`TCO_CTRL_ON] && !st.on_prev) begin
          next_st.mode = tco_pkg::TCO_RUN;
        end
      end
      tco_pkg::TCO_RUN: begin
        if (any_req) begin
          next_st.mode = tco_pkg::TCO_CUTOFF;
        end else if (st.ctrl[`TCO_CTRL_RAMPSTOP] || !st.ctrl[`TCO_CTRL_ON]) begin
          next_st.mode = tco_pkg::TCO_IDLE;
        end
      end
      tco_pkg::TCO_CUTOFF: begin
        if (!any_req) begin
          next_st.mode          = tco_pkg::TCO_INHIBIT;
          next_st.rampstop_seen = 1'b0;
        end
      end
      tco_pkg::TCO_INHIBIT: begin
        if (any_req) begin
          next_st.mode = tco_pkg::TCO_CUTOFF;
        end else if (st.ctrl[`TCO_CTRL_RAMPSTOP]) begin
          next_st.rampstop_seen = 1'b1;
        end else if (st.rampstop_seen && st.ctrl[`TCO_CTRL_ON] && !st.on_prev) begin
          next_st.mode = tco_pkg::TCO_RUN;
        end
      end
    endcase
    next_st.active     = (st.mode == tco_pkg::TCO_CUTOFF) && any_req;
    next_st.gate_en    = (next_st.mode == tco_pkg::TCO_RUN);
    next_st.brake_hold = next_st.ctrl[`TCO_CTRL_BRAKE] && (next_st.mode != tco_pkg::TCO_RUN);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st      <= '0;
      st.mode <= tco_pkg::TCO_IDLE;
      st.ctrl <= `TCO_CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata        = st.prdata;
  assign pready        = st.pready;
  assign pslverr       = st.pslverr;
  assign gate_enable   = st.gate_en;
  assign brake_apply   = st.brake_hold;
  assign cutoff_active = st.active;

  ////////////////////////////////////////////////////////////////////////////
  chk_active_needs_req: assert property (@(posedge pclk) disable iff (!presetn)
    st.active |-> st.selected)
    else $error("active flag without selection");

  chk_bus_source_bit: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st.ctrl[`TCO_CTRL_BUSREQ]) |=> st.bus_src)
    else $error("fieldbus source bit not set");

  chk_term_source_bit: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st.term_req) |=> st.term_src && st.selected)
    else $error("terminal source bit not set");

  chk_select_follows: assert property (@(posedge pclk) disable iff (!presetn)
    any_req |=> st.selected)
    else $error("selected flag missing");

  chk_active_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (st.mode == tco_pkg::TCO_RUN && any_req) ##1 any_req |=> st.active)
    else $error("active flag late");

  chk_no_torque: assert property (@(posedge pclk) disable iff (!presetn)
    st.active |-> !gate_enable)
    else $error("gate drive on during cut-off");

  chk_brake_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (st.active && st.ctrl[`TCO_CTRL_BRAKE]) |-> brake_apply)
    else $error("brake not applied");

  chk_withdraw_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (st.active && !any_req) |=> !st.selected && !st.active)
    else $error("flags not cleared on withdrawal");

  chk_inhibit_enter: assert property (@(posedge pclk) disable iff (!presetn)
    (st.mode == tco_pkg::TCO_CUTOFF && !any_req) |=> st.mode == tco_pkg::TCO_INHIBIT)
    else $error("inhibit not entered");

  chk_restart_order: assert property (@(posedge pclk) disable iff (!presetn)
    (st.mode == tco_pkg::TCO_INHIBIT && !st.rampstop_seen) |=> st.mode != tco_pkg::TCO_RUN)
    else $error("restart without ramp-stop");

  chk_stage_read: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !req.pwrite && req.paddr == `TCO_OFF_STAGE) |=> pready && prdata[7:0] == `TCO_STAGE_READY)
    else $error("stage selector not ready");

  chk_inactive_outside: assert property (@(posedge pclk) disable iff (!presetn)
    st.mode != tco_pkg::TCO_CUTOFF |-> !cutoff_active)
    else $error("active flag outside cut-off");

  chk_run_takes_req: assert property (@(posedge pclk) disable iff (!presetn)
    (st.mode == tco_pkg::TCO_RUN && any_req) |=> st.mode == tco_pkg::TCO_CUTOFF && !gate_enable)
    else $error("request ignored while running");

  chk_bus_source_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(st.ctrl[`TCO_CTRL_BUSREQ]) |=> !st.bus_src)
    else $error("fieldbus source bit stuck");

  chk_term_sync_agree: assert property (@(posedge pclk) disable iff (!presetn)
    st.term_req != $past(st.term_req) |-> $past(st.term_sync[2] == st.term_sync[1]))
    else $error("terminal request taken before stages agree");

  chk_term_source_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(st.term_req) |=> !st.term_src)
    else $error("terminal source bit stuck");

  chk_gate_only_run: assert property (@(posedge pclk) disable iff (!presetn)
    gate_enable |-> st.mode == tco_pkg::TCO_RUN)
    else $error("gate drive on outside run");

  chk_idle_no_torque: assert property (@(posedge pclk) disable iff (!presetn)
    st.mode == tco_pkg::TCO_IDLE |-> !gate_enable)
    else $error("gate drive on while idle");

  chk_brake_match: assert property (@(posedge pclk) disable iff (!presetn)
    brake_apply == (st.ctrl[`TCO_CTRL_BRAKE] && st.mode != tco_pkg::TCO_RUN))
    else $error("brake output wrong");

  chk_buffers_empty: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !req.pwrite && (req.paddr == `TCO_OFF_FAULTS || req.paddr == `TCO_OFF_ALARMS))
      |=> pready && !pslverr && prdata == 32'h0000_0000)
    else $error("fault or alarm buffer not empty");

  chk_selected_clear: assert property (@(posedge pclk) disable iff (!presetn)
    !any_req |=> !st.selected && !cutoff_active)
    else $error("flags set without request");

  chk_inhibit_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !req.pwrite && req.paddr == `TCO_OFF_ENABLES)
      |=> prdata[`TCO_ENA_INHIBIT] == $past(st.mode == tco_pkg::TCO_INHIBIT))
    else $error("inhibit flag wrong");

  chk_inhibit_no_torque: assert property (@(posedge pclk) disable iff (!presetn)
    st.mode == tco_pkg::TCO_INHIBIT |-> !gate_enable && !cutoff_active)
    else $error("torque or active flag during inhibit");

  chk_inhibit_stays: assert property (@(posedge pclk) disable iff (!presetn)
    (st.mode == tco_pkg::TCO_INHIBIT && !any_req) |=> st.mode inside {tco_pkg::TCO_INHIBIT, tco_pkg::TCO_RUN})
    else $error("inhibit left without restart");

  chk_restart_needs_on: assert property (@(posedge pclk) disable iff (!presetn)
    (st.mode != tco_pkg::TCO_RUN) ##1 (st.mode == tco_pkg::TCO_RUN)
      |-> $past(st.ctrl[`TCO_CTRL_ON]) && !$past(st.on_prev))
    else $error("run entered without fresh on");

  chk_either_source: assert property (@(posedge pclk) disable iff (!presetn)
    st.selected |-> st.bus_src || st.term_src)
    else $error("selection without source");

  ////////////////////////////////////////////////////////////////////////////
  // apb answer checks
  chk_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready longer than one cycle");

  chk_error_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

  chk_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");

  chk_ctrl_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> st.ctrl == $past(req.pwdata[3:0]))
    else $error("control write lost");

  chk_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !rd_ok) |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  chk_mapped_no_error: assert property (@(posedge pclk) disable iff (!presetn)
    (access && rd_ok) |=> pready && !pslverr)
    else $error("mapped access refused");

  // main scenario covers

  cov_bus_cutoff: cover property (@(posedge pclk) disable iff (!presetn)
    st.mode == tco_pkg::TCO_RUN ##1 st.bus_src ##[1:20] st.active);
  cov_term_cutoff: cover property (@(posedge pclk) disable iff (!presetn)
    st.mode == tco_pkg::TCO_RUN ##1 st.term_src ##[1:20] st.active);
  cov_restart: cover property (@(posedge pclk) disable iff (!presetn)
    st.mode == tco_pkg::TCO_INHIBIT ##[1:50] st.mode == tco_pkg::TCO_RUN);

  cov_withdraw: cover property (@(posedge pclk) disable iff (!presetn)
    st.mode == tco_pkg::TCO_CUTOFF ##1 st.mode == tco_pkg::TCO_INHIBIT);

  cov_brake_hold: cover property (@(posedge pclk) disable iff (!presetn)
    cutoff_active && brake_apply);

endmodule
`default_nettype wire

// ---- verification/tco_term_model.sv ----
// Purpose: wired fail-safe terminal source facing the cut-off block
// Assumes: one clock, request level active high
// Notes:   slow mode delays the request by five cycles, normal mode by one
`timescale 1ns/1ps
`default_nettype none
module tco_term_model (
  input  wire logic pclk,
  input  wire logic cmd,
  input  wire logic slow,
  output var  logic req
);
  logic [3:0] dly;
  always_ff @(posedge pclk) begin
    dly <= {dly[2:0], cmd};
    req <= slow ? dly[3] : cmd;
  end
endmodule
`default_nettype wire

// ---- verification/test_tco_torque_cutoff.sv ----
// Purpose: self-checking bench of the torque cut-off block
// Assumes: one-cycle apb wait state, terminal path via partner model
// Notes:   fieldbus and terminal paths alternate, brake fitted at random
`include "tco_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_tco_torque_cutoff;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        cmd, slow, req, gate, brake, act, brk, via;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int          n_errors, n_tests, cyc;

  tco_torque_cutoff tco_torque_cutoff_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_cutoff_req(req), .gate_enable(gate), .brake_apply(brake), .cutoff_active(act));
  tco_term_model tco_term_model_i (.pclk(pclk), .cmd(cmd), .slow(slow), .req(req));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  function automatic logic [31:0] saf_exp(input logic sel, input logic ac);
    return {30'h0, ac, sel};
  endfunction
  function automatic logic [31:0] src_exp(input logic bus, input logic term);
    return ({31'h0, bus} << `TCO_SRC_BUS) | ({31'h0, term} << `TCO_SRC_TERM);
  endfunction

  task automatic stop_test;
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, cmd, slow} = '0;
    paddr  = '0;
    pwdata = '0;
    void'($urandom(70295));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TCO_OFF_STAGE, {24'h0, `TCO_STAGE_READY});
    rd(`TCO_OFF_SAFETY, saf_exp(1'b0, 1'b0));
    apb(1'b0, 12'hFFC, 32'h0);
    check({r[30:0], e}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      brk = 1'($urandom);
      via = i[0];
      slow <= 1'($urandom);
      apb(1'b1, `TCO_OFF_CTRL, {28'h0, brk, 3'b001});
      settle(3);
      check(gate, 1'b1);
      if (via) begin
        @(posedge pclk);
        cmd <= 1'b1;
        settle(14);
      end else
        apb(1'b1, `TCO_OFF_CTRL, {28'h0, brk, 3'b101});
      rd(`TCO_OFF_SOURCE, src_exp(!via, via));
      rd(`TCO_OFF_SAFETY, saf_exp(1'b1, 1'b1));
      @(negedge pclk);
      check({gate, act}, 2'b01);
      check(brake, brk);
      rd(`TCO_OFF_FAULTS, 32'h0);
      if (via) begin
        @(posedge pclk);
        cmd <= 1'b0;
        settle(14);
      end else
        apb(1'b1, `TCO_OFF_CTRL, {28'h0, brk, 3'b001});
      rd(`TCO_OFF_SAFETY, saf_exp(1'b0, 1'b0));
      rd(`TCO_OFF_ENABLES, 32'h1);
      rd(`TCO_OFF_ALARMS, 32'h0);
      @(negedge pclk);
      check(gate, 1'b0);
      apb(1'b1, `TCO_OFF_CTRL, 32'h0);
      apb(1'b1, `TCO_OFF_CTRL, {28'h0, brk, 3'b001});
      settle(3);
      check(gate, 1'b0);
      apb(1'b1, `TCO_OFF_CTRL, 32'h2);
      apb(1'b1, `TCO_OFF_CTRL, 32'h0);
      apb(1'b1, `TCO_OFF_CTRL, {28'h0, brk, 3'b001});
      settle(3);
      check(gate, 1'b1);
      apb(1'b1, `TCO_OFF_CTRL, 32'h0);
    end
    stop_test();
  end
endmodule
`default_nettype wire
